//--- pmm_top.sv
/*
 Program memory map, code protection and identification words.
 Assumes the core drives the fetch and indirect requests synchronous to pclk,
 that program flash returns data in the same cycle as its address, and an APB master.
*/
// Implementation choice: register access over APB.
// What this block does
// - Configuration word five bit 0 at 1 disables code protection, 0 enables it.
// - Code protection acts at once; programmer writes this word last.
// - Protection, once enabled, clears only through bulk erase or presetn.
// - Part word reads 1 in bits 13:12 and the part code in 11:0.
// - Revision word reads 1 in bit 13, 0 in bit 12, major and minor.
// - Major field marks lettered silicon steps; minor marks steps within them.
// - Program counter is 15 bits wide over 32K words of 14 bits.
// - Addresses past implemented memory wrap into the implemented space.
// - Reset starts at 0000h and interrupts vector to 0004h.
// - Implemented memory is 2048 words to 07FFh or 4096 words to 0FFFh.
// - Pointer high byte bit 7 set makes indirect reads fetch program memory.
// - Indirect move from program memory loads only the low eight bits.
// - Indirect writes aimed at program memory leave it untouched.
// - Indirect program memory reads take one extra instruction cycle.
// - Flash splits into application, optional boot and storage blocks by settings.
// - Boot and storage both disabled gives all flash to the application.
// - Enabled boot block starts at zero with extent from size select.
// - Boot block disable bit is an active low enable: 1 disables, 0 enables.
// - Boot block never exceeds half the memory; larger selections clamp there.
// - Enabled storage area is the last 128 words; a fetch from it raises exec_violation.
`timescale 1ns/1ps
module pmm_top #(
   parameter bit LARGE_VARIANT = 1'b0,
   parameter logic [11:0] PART_CODE = 12'h5a5,
   parameter logic [5:0] MAJOR_REV = 6'h01,
   parameter logic [5:0] MINOR_REV = 6'h00
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pc_load,
   input wire logic [pmm_pkg::PC_W-1:0] pc_load_addr,
   input wire logic pc_inc,
   input wire logic irq_take,
   output logic [pmm_pkg::PC_W-1:0] fetch_addr,
   output logic [2:0] fetch_region,
   output logic exec_violation,
   input wire logic [15:0] ind_ptr,
   input wire logic ind_rd,
   input wire logic ind_wr,
   output logic ind_is_prog,
   output logic ind_busy,
   output logic [7:0] ind_rdata,
   output logic ind_rvalid,
   output logic data_wr_en,
   output logic [pmm_pkg::PC_W-1:0] flash_addr,
   input wire logic [pmm_pkg::WORD_W-1:0] flash_rdata,
   input wire logic ext_rd,
   input wire logic [pmm_pkg::PC_W-1:0] ext_addr,
   output logic [pmm_pkg::WORD_W-1:0] ext_rdata,
   output logic code_protected
);
   import pmm_pkg::*;

   logic [15:0] configuration_word_five_q;
   logic [15:0] config4_q;
   logic [PC_W-1:0] pc_q;
   logic [PC_W-1:0] pc_d;
   logic [PC_W-1:0] last_addr;
   logic [PC_W-1:0] boot_end;
   logic [PC_W-1:0] saf_start;
   logic [PC_W-1:0] ind_addr_q;
   logic [31:0] prdata_q;
   logic [31:0] rd_mux;
   logic [WORD_W-1:0] ext_rdata_q;
   logic [7:0] ind_rdata_q;
   logic ind_rvalid_q;
   logic slverr_q;
   logic hit;
   logic wr_acc;
   logic setup;
   logic erase_req;
   logic boot_on;
   logic saf_on;
   pmm_ind_state_t ind_state_q;

   function automatic logic is_idx(input logic [31:0] a, input logic [15:0] idx);
      is_idx = (a == {14'h0000, idx, 2'b00});
   endfunction

   function automatic logic [PC_W-1:0] wrap(input logic [PC_W-1:0] a,
                                              input logic [PC_W-1:0] last);
      wrap = a & last;
   endfunction

   function automatic logic [2:0] classify(input logic [PC_W-1:0] a,
                                           input logic bb, input logic sf,
                                           input logic [PC_W-1:0] bend,
                                           input logic [PC_W-1:0] sstart);
      if (bb && a <= bend) begin
         classify = PMM_BOOT;
      end else if (sf && a >= sstart) begin
         classify = PMM_SAF;
      end else begin
         classify = PMM_APP;
      end
   endfunction

   // Size of the implemented space.
   always_comb begin
      if (LARGE_VARIANT) begin
         last_addr = LAST_LARGE;
      end else begin
         last_addr = LAST_SMALL;
      end
   end

   // Partition settings; the disables are active low enables.
   always_comb begin
      boot_on = ~config4_q[BB_DIS_BIT];
      saf_on = ~config4_q[SAF_DIS_BIT];
      saf_start = last_addr - SAF_SPAN;
   end

   // Boot end doubles per step down of the select and clamps at half memory.
   always_comb begin
      logic [PC_W-1:0] raw;
      raw = BB_BASE_END;
      case (config4_q[BB_SIZE_LSB +: 3])
         3'b111: raw = BB_BASE_END;
         3'b110: raw = {BB_BASE_END[PC_W-2:0], 1'b1};
         3'b101: raw = {BB_BASE_END[PC_W-3:0], 2'b11};
         3'b100: raw = {BB_BASE_END[PC_W-4:0], 3'b111};
         default: raw = {BB_BASE_END[PC_W-5:0], 4'hf};
      endcase
      boot_end = (raw > (last_addr >> 1)) ? (last_addr >> 1) : raw;
   end

   // Program counter with vectors and wrap-around.
   always_comb begin
      pc_d = pc_q;
      if (irq_take) begin
         pc_d = IRQ_VEC;
      end else if (pc_load) begin
         pc_d = pc_load_addr;
      end else if (pc_inc) begin
         pc_d = pc_q + 15'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_q <= RESET_VEC;
      end else begin
         pc_q <= pc_d;
      end
   end

   assign fetch_addr = wrap(pc_q, last_addr);
   assign fetch_region = classify(fetch_addr, boot_on, saf_on, boot_end, saf_start);
   assign exec_violation = (fetch_region == PMM_SAF);

   // Indirect access to program memory.
   assign ind_is_prog = ind_ptr[IND_PROG_BIT];
   assign data_wr_en = ind_wr & ~ind_is_prog;

   // A program read stalls the core for one extra cycle.
   always_comb begin
      ind_busy = 1'b0;
      if (ind_rd && ind_is_prog && ind_state_q == PMM_IDLE) begin
         ind_busy = 1'b1;
      end
   end

   // Flash sees the captured pointer during the extra cycle.
   always_comb begin
      if (ind_state_q == PMM_EXTRA) begin
         flash_addr = ind_addr_q;
      end else begin
         flash_addr = fetch_addr;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ind_addr_q <= RESET_VEC;
      end else if (ind_busy) begin
         ind_addr_q <= wrap(ind_ptr[PC_W-1:0], last_addr);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ind_state_q <= PMM_IDLE;
      end else begin
         case (ind_state_q)
            PMM_IDLE: begin
               if (ind_busy) begin
                  ind_state_q <= PMM_EXTRA;
               end
            end
            PMM_EXTRA: begin
               ind_state_q <= PMM_IDLE;
            end
            default: begin
               ind_state_q <= PMM_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ind_rvalid_q <= 1'b0;
      end else begin
         ind_rvalid_q <= (ind_state_q == PMM_EXTRA);
      end
   end

   // Only the low byte of the 14-bit word reaches the core.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ind_rdata_q <= 8'h00;
      end else if (ind_state_q == PMM_EXTRA) begin
         ind_rdata_q <= flash_rdata[7:0];
      end
   end

   assign ind_rdata = ind_rdata_q;
   assign ind_rvalid = ind_rvalid_q;

   // Code protection on the outside read path.
   assign code_protected = ~configuration_word_five_q[CP_BIT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_rdata_q <= 14'h0000;
      end else if (ext_rd) begin
         if (code_protected) begin
            ext_rdata_q <= 14'h0000;
         end else begin
            ext_rdata_q <= flash_rdata;
         end
      end
   end

   assign ext_rdata = ext_rdata_q;

   // APB slave; the answer comes in the first access cycle.
   always_comb begin
      setup = psel & ~penable;
      pready = psel & penable;
      pslverr = psel & penable & slverr_q;
   end

   // A write lands only in the access phase of a mapped address.
   always_comb begin
      wr_acc = psel & penable & pwrite & ~slverr_q;
      erase_req = wr_acc & is_idx(paddr, ERASE_IDX) & pwdata[ERASE_BIT];
   end

   assign prdata = prdata_q;

   always_comb begin
      hit = 1'b1;
      rd_mux = 32'h0000_0000;
      if (is_idx(paddr, REVISION_IDX)) begin
         rd_mux = {18'h00000, REV_TOP, MAJOR_REV, MINOR_REV};
      end else if (is_idx(paddr, PART_IDX)) begin
         rd_mux = {18'h00000, PART_TOP, PART_CODE};
      end else if (is_idx(paddr, CONFIG4_IDX)) begin
         rd_mux = {16'h0000, config4_q};
      end else if (is_idx(paddr, CONFIGURATION_WORD_FIVE_IDX)) begin
         rd_mux = {16'h0000, configuration_word_five_q};
      end else if (is_idx(paddr, STATUS_IDX)) begin
         rd_mux = {25'h0000000, saf_on, boot_on, code_protected,
                   exec_violation, fetch_region};
      end else if (!is_idx(paddr, ERASE_IDX)) begin
         hit = 1'b0;
      end
   end

   // Read data is captured in the setup cycle and stands until the next one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup) begin
         if (pwrite) begin
            prdata_q <= 32'h0000_0000;
         end else begin
            prdata_q <= rd_mux;
         end
      end
   end

   // Unmapped addresses answer with an error and ignore writes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slverr_q <= 1'b0;
      end else if (setup) begin
         slverr_q <= ~hit;
      end
   end

   // Configuration word five; a write can only set protection, erase clears it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         configuration_word_five_q <= CONFIGURATION_WORD_FIVE_RST;
      end else if (erase_req) begin
         configuration_word_five_q <= CONFIGURATION_WORD_FIVE_RST;
      end else if (wr_acc && is_idx(paddr, CONFIGURATION_WORD_FIVE_IDX)) begin
         configuration_word_five_q[CP_BIT] <= configuration_word_five_q[CP_BIT] & pwdata[CP_BIT];
      end
   end

   // Partition word; size is frozen once the boot block is enabled.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config4_q <= CONFIG4_RST;
      end else if (erase_req) begin
         config4_q <= CONFIG4_RST;
      end else if (wr_acc && is_idx(paddr, CONFIG4_IDX)) begin
         config4_q[SAF_DIS_BIT] <= pwdata[SAF_DIS_BIT];
         config4_q[BB_DIS_BIT] <= pwdata[BB_DIS_BIT] & config4_q[BB_DIS_BIT];
         if (config4_q[BB_DIS_BIT]) begin
            config4_q[BB_SIZE_LSB +: 3] <= pwdata[BB_SIZE_LSB +: 3];
         end
      end
   end
endmodule

//--- pmm_pkg.sv
/*
 Constants for the program memory map and identification block.
 Assumes a 40 MHz APB clock and a 32-bit APB data path.
*/
package pmm_pkg;
   // Register indices; the APB byte address is four times the index.
   localparam logic [15:0] REVISION_IDX = 16'h8005;
   localparam logic [15:0] PART_IDX = 16'h8006;
   localparam logic [15:0] CONFIG4_IDX = 16'h800a;
   localparam logic [15:0] CONFIGURATION_WORD_FIVE_IDX = 16'h800b;
   localparam logic [15:0] ERASE_IDX = 16'h8010;
   localparam logic [15:0] STATUS_IDX = 16'h8011;
   localparam int CP_BIT = 0;
   localparam int SAF_DIS_BIT = 4;
   localparam int BB_DIS_BIT = 3;
   localparam int BB_SIZE_LSB = 0;
   localparam int ERASE_BIT = 0;
   localparam logic [15:0] CONFIGURATION_WORD_FIVE_RST = 16'h0001;
   localparam logic [15:0] CONFIG4_RST = 16'h001f;
   localparam logic [1:0] PART_TOP = 2'b11;
   localparam logic [1:0] REV_TOP = 2'b10;
   localparam int PC_W = 15;
   localparam int WORD_W = 14;
   localparam logic [14:0] RESET_VEC = 15'h0000;
   localparam logic [14:0] IRQ_VEC = 15'h0004;
   localparam logic [14:0] LAST_SMALL = 15'h07ff;
   localparam logic [14:0] LAST_LARGE = 15'h0fff;
   localparam logic [14:0] SAF_SPAN = 15'h007f;
   localparam logic [14:0] BB_BASE_END = 15'h01ff;
   localparam int IND_PROG_BIT = 15;
   typedef enum logic [2:0] {
      PMM_BOOT = 3'b001,
      PMM_APP = 3'b010,
      PMM_SAF = 3'b100
   } pmm_region_t;
   typedef enum logic [1:0] {
      PMM_IDLE = 2'b01,
      PMM_EXTRA = 2'b10
   } pmm_ind_state_t;
endpackage

//--- pmm_monitor.sv
/*
 Concurrent checks on the ports of the program memory map block.
 Assumes one pclk domain with presetn as its asynchronous reset.
*/
`timescale 1ns/1ps
module pmm_monitor #(
   parameter bit LARGE_VARIANT = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pc_load,
   input wire logic [pmm_pkg::PC_W-1:0] pc_load_addr,
   input wire logic irq_take,
   input wire logic [pmm_pkg::PC_W-1:0] fetch_addr,
   input wire logic [2:0] fetch_region,
   input wire logic exec_violation,
   input wire logic [15:0] ind_ptr,
   input wire logic ind_rd,
   input wire logic ind_rvalid,
   input wire logic [7:0] ind_rdata,
   input wire logic [pmm_pkg::PC_W-1:0] flash_addr,
   input wire logic [pmm_pkg::WORD_W-1:0] flash_rdata,
   input wire logic code_protected
);
   import pmm_pkg::*;
   localparam logic [14:0] LAST = LARGE_VARIANT ? LAST_LARGE : LAST_SMALL;
   logic wr_c5;
   logic erase;
   assign wr_c5 = psel && penable && pwrite && paddr == {14'h0, CONFIGURATION_WORD_FIVE_IDX, 2'b00};
   assign erase = psel && penable && pwrite && paddr == {14'h0, ERASE_IDX, 2'b00} && pwdata[0];
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   apb_ready_a: assert property (psel && penable |-> pready)
      else $error("access phase without ready");
   prot_set_a: assert property (wr_c5 && !pwdata[0] && !erase |=> code_protected)
      else $error("protection not set at once");
   prot_keep_a: assert property (code_protected && !erase |=> code_protected)
      else $error("protection cleared without erase");
   prot_erase_a: assert property (erase |=> !code_protected)
      else $error("erase left protection on");
   irq_vec_a: assert property (irq_take |=> fetch_addr == IRQ_VEC)
      else $error("interrupt vector wrong");
   pc_wrap_a: assert property (pc_load && !irq_take |=> fetch_addr == ($past(pc_load_addr) & LAST))
      else $error("loaded address not wrapped");
   ind_read_a: assert property (ind_rd && ind_ptr[15] |=>
      ({1'b0, flash_addr} == ($past(ind_ptr) & {1'b0, LAST})) ##1
      (ind_rvalid && ind_rdata == 8'($past(flash_rdata)))) else $error("indirect read wrong");
   saf_exec_a: assert property (exec_violation |->
      fetch_region == 3'b100 && fetch_addr >= LAST - SAF_SPAN) else $error("violation outside storage");
   cover property (ind_rvalid);
   cover property (exec_violation);
   cover property ($rose(code_protected));
endmodule

bind pmm_top pmm_monitor #(.LARGE_VARIANT(LARGE_VARIANT)) i_pmm_monitor (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .pc_load(pc_load), .pc_load_addr(pc_load_addr),
   .irq_take(irq_take), .fetch_addr(fetch_addr), .fetch_region(fetch_region),
   .exec_violation(exec_violation), .ind_ptr(ind_ptr), .ind_rd(ind_rd), .ind_rvalid(ind_rvalid),
   .ind_rdata(ind_rdata), .flash_addr(flash_addr), .flash_rdata(flash_rdata),
   .code_protected(code_protected));

//--- tb_pmm_top.sv
/*
 Self-checking bench for the program memory map block.
 Assumes the package and checker are compiled first; flash is modelled here.
*/
`timescale 1ns/1ps
module tb_pmm_top;
   import pmm_pkg::*;
   localparam logic [11:0] PCODE = 12'h3c9; // Arbitrary part code.
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic pc_load = 0, pc_inc = 0, irq_take = 0, ind_rd = 0, ind_wr = 0, ext_rd = 0;
   logic ind_is_prog, ind_busy, ind_rvalid, data_wr_en, exec_violation, code_protected;
   logic [31:0] paddr = 0, pwdata = 0, prdata;
   logic [14:0] pc_load_addr = 0, fetch_addr, flash_addr;
   logic [14:0] pa[4] = '{15'h03ff, 15'h0400, 15'h077f, 15'h0780};
   logic [2:0] pr[4] = '{3'b001, 3'b010, 3'b010, 3'b100};
   logic [15:0] ind_ptr = 0;
   logic [2:0] fetch_region;
   logic [7:0] ind_rdata;
   logic [13:0] flash_rdata, ext_rdata;
   logic [32:0] q_rd[$];
   logic [7:0] q_ind[$];
   int num_errors = 0, checked = 0, cyc = 0, seed = 32'hbbfbf921;
   function automatic logic [13:0] fw(input logic [14:0] a);
      return {a[5:0], a[13:6]} ^ 14'h1234;
   endfunction
   assign flash_rdata = fw(flash_addr);
   pmm_top #(.LARGE_VARIANT(1'b0), .PART_CODE(PCODE), .MAJOR_REV(6'h02), .MINOR_REV(6'h05))
   i_pmm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pc_load(pc_load), .pc_load_addr(pc_load_addr), .pc_inc(pc_inc), .irq_take(irq_take),
      .fetch_addr(fetch_addr), .fetch_region(fetch_region), .exec_violation(exec_violation),
      .ind_ptr(ind_ptr), .ind_rd(ind_rd), .ind_wr(ind_wr), .ind_is_prog(ind_is_prog),
      .ind_busy(ind_busy), .ind_rdata(ind_rdata), .ind_rvalid(ind_rvalid),
      .data_wr_en(data_wr_en), .flash_addr(flash_addr), .flash_rdata(flash_rdata),
      .ext_rd(ext_rd), .ext_addr(15'h0000), .ext_rdata(ext_rdata),
      .code_protected(code_protected));
   initial begin
      forever #12.5 pclk = ~pclk;
   end
   task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checked %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {14'h0, idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [15:0] idx, input logic [32:0] e);
      q_rd.push_back(e);
      apb(1'b0, idx, 32'h0);
   endtask
   task automatic ld(input logic [14:0] a, input logic irq);
      pc_load_addr <= a;
      pc_load <= 1'b1;
      irq_take <= irq;
      @(posedge pclk);
      pc_load <= 1'b0;
      irq_take <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic ird(input logic [15:0] p);
      logic [14:0] w;
      w = p[14:0] & LAST_SMALL;
      q_ind.push_back(8'(fw(w)));
      ind_ptr <= p;
      ind_rd <= 1'b1;
      @(posedge pclk);
      chk("ind_busy", ind_busy, 1);
      ind_rd <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
         chk("prdata", {pslverr, prdata}, q_rd.pop_front());
      if (ind_rvalid === 1'b1) chk("ind_rdata", ind_rdata, q_ind.pop_front());
      cyc++;
      if (cyc == 4000) begin
         num_errors++;
         conclude();
      end
   end
   initial begin
      logic [14:0] a;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("fetch_addr", fetch_addr, RESET_VEC);
      chk("fetch_region", fetch_region, 3'b010);
      rd(REVISION_IDX, {19'h0, REV_TOP, 6'h02, 6'h05});
      rd(PART_IDX, {19'h0, PART_TOP, PCODE});
      apb(1'b1, PART_IDX, 32'hffff);
      rd(PART_IDX, {19'h0, PART_TOP, PCODE});
      rd(CONFIG4_IDX, {17'h0, CONFIG4_RST});
      rd(CONFIGURATION_WORD_FIVE_IDX, {17'h0, CONFIGURATION_WORD_FIVE_RST});
      rd(STATUS_IDX, 33'h2);
      rd(16'h8007, {1'b1, 32'h0});
      $display("test registers done");
      ld(15'h0123, 1'b1);
      chk("fetch_addr", fetch_addr, IRQ_VEC);
      for (int i = 0; i < 8; i++) begin
         a = 15'($random(seed));
         ld(a, 1'b0);
         chk("fetch_addr", fetch_addr, a & LAST_SMALL);
      end
      ld(LAST_SMALL, 1'b0);
      pc_inc <= 1'b1;
      @(posedge pclk);
      pc_inc <= 1'b0;
      @(posedge pclk);
      chk("fetch_addr", fetch_addr, 0);
      $display("test counter done");
      apb(1'b1, CONFIG4_IDX, 32'h05);
      apb(1'b1, CONFIG4_IDX, 32'h06);
      rd(CONFIG4_IDX, 33'h05);
      foreach (pa[i]) begin
         ld(pa[i], 1'b0);
         chk("fetch_region", fetch_region, pr[i]);
         chk("exec_violation", exec_violation, pr[i][2]);
      end
      rd(STATUS_IDX, 33'h6c);
      $display("test partition done");
      ird(16'h8000 | 16'($random(seed)));
      ird(16'h8fff);
      ind_ptr <= 16'h8010;
      ind_wr <= 1'b1;
      @(posedge pclk);
      chk("data_wr_en", data_wr_en, 0);
      ind_ptr <= 16'h0010;
      @(posedge pclk);
      chk("data_wr_en", data_wr_en, 1);
      chk("ind_is_prog", ind_is_prog, 0);
      ind_wr <= 1'b0;
      $display("test indirect done");
      for (int i = 0; i < 2; i++) begin
         ext_rd <= 1'b1;
         @(posedge pclk);
         ext_rd <= 1'b0;
         @(posedge pclk);
         chk("ext_rdata", ext_rdata, i ? 14'h0 : fw(15'h0780));
         apb(1'b1, CONFIGURATION_WORD_FIVE_IDX, 32'h0);
         chk("code_protected", code_protected, 1);
      end
      apb(1'b1, CONFIGURATION_WORD_FIVE_IDX, 32'h1);
      rd(CONFIGURATION_WORD_FIVE_IDX, 33'h0);
      apb(1'b1, ERASE_IDX, 32'h1);
      chk("code_protected", code_protected, 0);
      rd(CONFIG4_IDX, {17'h0, CONFIG4_RST});
      chk("pending", q_rd.size() + q_ind.size(), 0);
      $display("test protection done");
      conclude();
   end
endmodule
